// *** hdl/msc_regs.sv ***
// serial register bank for mode, supply and hardware configuration
`timescale 1ns/1ps
// Overview of operation
// - each frame is 16 bits: 7-bit address, access bit, then data byte
// - frame bit 7 low reads only, high writes the data byte
// - data bits D0 to D7 travel as frame bits 8 to 15
// - reserved bits read as zero; host writes zero there
// - read-only bits ignore writes; only h bits change by hardware
// - reset loads reset values; restart loads restart values, keeping marked bits
// - mode field 7:6: normal, sleep, stop, 11 gives soft reset
// - sleep request while in stop does not leave stop
// - restart forces normal mode, keeps aux enable and threshold
// - bit 5 enables the auxiliary regulator
// - bits 4:3 select when the second regulator is on
// - restart or overtemperature turns second regulator control off
// - overvoltage flag always sets; bit 2 allows restart or fail-safe
// - bits 1:0 select one of four main reset thresholds
// - a write shifts out the value held before the write
// - restart clears configuration bits 5, 2 and 1 only
// - bit 6 low lets soft reset pull the reset output low
// - bit 5 forces failure outputs; device clears it on restart
// - bit 3 selects aux load sharing; bit 1 allows it in stop
// - config bit 0 low escalates after the second watchdog failure
// - soft reset keeps bits 7 and 3; power-on clears all
module msc_regs #(
    parameter int RO_CNT_W = 8
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_SPI_SCK,
    input wire logic I_SPI_CSN,
    input wire logic I_SPI_MOSI,
    output logic O_SPI_MISO,
    output logic O_SPI_MISO_OE,
    input wire logic I_RESTART,
    input wire logic I_OVERTEMP,
    input wire logic I_MAIN_OV,
    input wire logic I_SUPPLY_UV,
    input wire logic I_FAILURE,
    input wire logic I_FAIL_SAFE,
    input wire logic I_WD_TRIG_FAIL,
    output logic [1:0] O_MODE,
    output logic O_SOFT_RESET_REQ,
    output logic O_RESET_OUT_N,
    output logic O_SECOND_REG_EN,
    output logic O_AUX_REG_EN,
    output logic O_AUX_VSEL,
    output logic O_AUX_LOAD_SHARE,
    output logic O_AUX_LS_STOP,
    output logic [1:0] O_RESET_THRESHOLD,
    output logic O_MAIN_OV_FLAG,
    output logic O_OV_ESCALATE,
    output logic O_WD_ESCALATE,
    output logic O_FAIL_OUT
);
    if (msc_pkg::RO_LOW_CYC >= 2 ** RO_CNT_W) begin : g_chk
        $error("RO_CNT_W too narrow for the reset output low time");
    end

    // ---------------- serial clock domain ----------------
    logic spi_rst;
    logic [4:0] cnt_q;
    logic [15:0] frame_q;
    logic [15:0] word_q;
    logic done_tgl_q;
    logic miso_q;
    logic [7:0] rd_byte;
    logic [7:0] snap_ms_q;
    logic [7:0] snap_hw_q;

    // chip select high aborts any partial frame
    assign spi_rst = I_RST | I_SPI_CSN;

    always_ff @(posedge I_SPI_SCK or posedge spi_rst) begin
        if (spi_rst) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != 5'h10) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // bits land at their frame position, first bit is bit 0
    always_ff @(posedge I_SPI_SCK or posedge spi_rst) begin
        if (spi_rst) begin
            frame_q <= 16'h0000;
        end else if (cnt_q != 5'h10) begin
            frame_q[cnt_q[3:0]] <= I_SPI_MOSI;
        end
    end

    // whole word handed over at the 16th edge; held until next frame ends
    always_ff @(posedge I_SPI_SCK or posedge I_RST) begin
        if (I_RST) begin
            word_q <= 16'h0000;
            done_tgl_q <= 1'b0;
        end else if (cnt_q == 5'h0F) begin
            word_q <= {I_SPI_MOSI, frame_q[14:0]};
            done_tgl_q <= ~done_tgl_q;
        end
    end

    // snapshot is frozen while the frame runs, so a write returns old data
    always_comb begin
        rd_byte = 8'h00;
        if (frame_q[6:0] == msc_pkg::ADDR_MODE_SUPPLY) begin
            rd_byte = snap_ms_q;
        end else if (frame_q[6:0] == msc_pkg::ADDR_HW_CONFIG) begin
            rd_byte = snap_hw_q;
        end
    end

    // shift out on falling edge; first byte is all zero
    always_ff @(negedge I_SPI_SCK or posedge spi_rst) begin
        if (spi_rst) begin
            miso_q <= 1'b0;
        end else if (cnt_q[4:3] == 2'b01) begin
            miso_q <= rd_byte[cnt_q[2:0]];
        end else begin
            miso_q <= 1'b0;
        end
    end

    assign O_SPI_MISO = miso_q;
    assign O_SPI_MISO_OE = ~I_SPI_CSN;

    // ---------------- reference clock domain ----------------
    logic [8:0] sync_in;
    logic [8:0] sync_out;
    logic tgl_s, csn_s, restart_s, ovt_s, ov_s, uv_s, fail_s, fsafe_s, wdf_s;
    logic tgl_seen_q, restart_prev_q, ovt_prev_q, wdf_prev_q;
    logic wr_go, wr_is_write, restart_ev, ovt_ev, wdf_ev, soft_ev;
    logic wr_ms, wr_hw;
    logic [7:0] ms_q, ms_d, hw_q, hw_d;
    logic [RO_CNT_W-1:0] ro_cnt_q;
    logic [1:0] cur_mode, new_mode;

    assign sync_in = {done_tgl_q, I_SPI_CSN, I_RESTART, I_OVERTEMP, I_MAIN_OV,
                      I_SUPPLY_UV, I_FAILURE, I_FAIL_SAFE, I_WD_TRIG_FAIL};

    msc_sync #(
        .WIDTH(9),
        .RESET_VAL(9'h080)
    ) u_sync (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    assign {tgl_s, csn_s, restart_s, ovt_s, ov_s, uv_s, fail_s, fsafe_s, wdf_s} = sync_out;

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            tgl_seen_q <= 1'b0;
            restart_prev_q <= 1'b0;
            ovt_prev_q <= 1'b0;
            wdf_prev_q <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_s;
            restart_prev_q <= restart_s;
            ovt_prev_q <= ovt_s;
            wdf_prev_q <= wdf_s;
        end
    end

    assign wr_go = tgl_s ^ tgl_seen_q;
    assign wr_is_write = wr_go & word_q[msc_pkg::RW_BIT];
    assign wr_ms = wr_is_write && word_q[6:0] == msc_pkg::ADDR_MODE_SUPPLY;
    assign wr_hw = wr_is_write && word_q[6:0] == msc_pkg::ADDR_HW_CONFIG;
    assign restart_ev = restart_s & ~restart_prev_q;
    assign ovt_ev = ovt_s & ~ovt_prev_q;
    assign wdf_ev = wdf_s & ~wdf_prev_q;
    assign new_mode = word_q[msc_pkg::DATA_LSB + msc_pkg::MS_MODE_LSB +: 2];
    assign cur_mode = ms_q[msc_pkg::MS_MODE_LSB +: 2];
    assign soft_ev = wr_ms && new_mode == msc_pkg::MODE_SOFT_RESET;

    // snapshot refreshed only while chip select is high
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            snap_ms_q <= msc_pkg::MODE_SUPPLY_RST;
            snap_hw_q <= msc_pkg::HW_CONFIG_RST;
        end else if (csn_s) begin
            snap_ms_q <= ms_q;
            snap_hw_q <= hw_q;
        end
    end

    always_comb begin
        ms_d = ms_q;
        if (restart_ev) begin
            ms_d = ms_q & msc_pkg::MS_RESTART_KEEP;
        end else if (soft_ev) begin
            ms_d = msc_pkg::MODE_SUPPLY_RST;
        end else begin
            if (wr_ms) begin
                ms_d = word_q[15:8];
                if (new_mode == msc_pkg::MODE_SLEEP && cur_mode == msc_pkg::MODE_STOP) begin
                    ms_d[msc_pkg::MS_MODE_LSB +: 2] = msc_pkg::MODE_STOP;
                end
            end
            if (ovt_ev) begin
                ms_d[msc_pkg::MS_SEC_LSB +: 2] = msc_pkg::SEC_OFF;
            end
        end
    end

    always_comb begin
        hw_d = hw_q;
        if (restart_ev) begin
            hw_d = hw_q & msc_pkg::HW_RESTART_KEEP;
        end else if (soft_ev) begin
            hw_d = hw_q & msc_pkg::HW_SOFT_KEEP;
        end else if (wr_hw) begin
            hw_d = word_q[15:8] & msc_pkg::HW_WRITE_MASK;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            ms_q <= msc_pkg::MODE_SUPPLY_RST;
            hw_q <= msc_pkg::HW_CONFIG_RST;
        end else begin
            ms_q <= ms_d;
            hw_q <= hw_d;
        end
    end

    // reset output pulse during soft reset
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            ro_cnt_q <= '0;
            O_RESET_OUT_N <= 1'b1;
        end else if (soft_ev && !hw_q[msc_pkg::HW_SOFT_RO_MASK_BIT]) begin
            ro_cnt_q <= RO_CNT_W'(msc_pkg::RO_LOW_CYC);
            O_RESET_OUT_N <= 1'b0;
        end else if (ro_cnt_q != '0) begin
            ro_cnt_q <= ro_cnt_q - 1'b1;
            O_RESET_OUT_N <= (ro_cnt_q == RO_CNT_W'(1));
        end
    end

    msc_wd_escalate u_wd (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_fail(wdf_ev),
        .i_single(hw_q[msc_pkg::HW_WD_CFG_BIT]),
        .i_clear(restart_ev),
        .o_escalate(O_WD_ESCALATE)
    );

    // regulator and pin controls
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_MODE <= msc_pkg::MODE_NORMAL;
            O_SOFT_RESET_REQ <= 1'b0;
            O_SECOND_REG_EN <= 1'b0;
            O_AUX_REG_EN <= 1'b0;
            O_AUX_VSEL <= 1'b0;
            O_AUX_LOAD_SHARE <= 1'b0;
            O_AUX_LS_STOP <= 1'b0;
            O_RESET_THRESHOLD <= 2'b00;
            O_FAIL_OUT <= 1'b0;
        end else begin
            O_MODE <= cur_mode;
            O_SOFT_RESET_REQ <= soft_ev;
            case (ms_q[msc_pkg::MS_SEC_LSB +: 2])
                msc_pkg::SEC_NORMAL: O_SECOND_REG_EN <= cur_mode == msc_pkg::MODE_NORMAL;
                msc_pkg::SEC_NORMAL_STOP: O_SECOND_REG_EN <= cur_mode == msc_pkg::MODE_NORMAL
                                                        || cur_mode == msc_pkg::MODE_STOP;
                msc_pkg::SEC_ALWAYS: O_SECOND_REG_EN <= ~fsafe_s;
                default: O_SECOND_REG_EN <= 1'b0;
            endcase
            O_AUX_REG_EN <= ms_q[msc_pkg::MS_AUX_EN_BIT]
                && !(uv_s && !hw_q[msc_pkg::HW_AUX_UV_KEEP_BIT]);
            O_AUX_VSEL <= hw_q[msc_pkg::HW_AUX_VSEL_BIT];
            O_AUX_LOAD_SHARE <= hw_q[msc_pkg::HW_AUX_LS_BIT];
            O_AUX_LS_STOP <= hw_q[msc_pkg::HW_AUX_LS_BIT] && hw_q[msc_pkg::HW_LS_STOP_BIT];
            O_RESET_THRESHOLD <= ms_q[msc_pkg::MS_RT_LSB +: 2];
            O_FAIL_OUT <= hw_q[msc_pkg::HW_FO_FORCE_BIT] || fail_s;
        end
    end

    // overvoltage flag sticky, escalation gated by enable bit
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_MAIN_OV_FLAG <= 1'b0;
            O_OV_ESCALATE <= 1'b0;
        end else begin
            if (ov_s) begin
                O_MAIN_OV_FLAG <= 1'b1;
            end
            O_OV_ESCALATE <= ov_s && ms_q[msc_pkg::MS_OV_RST_BIT];
        end
    end

    // ---------------- checks ----------------
    a_stop_no_sleep: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        wr_ms && !restart_ev && new_mode == msc_pkg::MODE_SLEEP
        && cur_mode == msc_pkg::MODE_STOP |=> cur_mode == msc_pkg::MODE_STOP)
        else $error("stop left for sleep");

    a_restart_ms_pattern: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        restart_ev |=> ms_q[7:6] == 2'b00 && ms_q[4:2] == 3'b000
        && ms_q[5] == $past(ms_q[5]) && ms_q[1:0] == $past(ms_q[1:0]))
        else $error("mode register restart pattern wrong");

    a_restart_hw_pattern: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        restart_ev |=> hw_q[5] == 1'b0 && hw_q[2:1] == 2'b00
        && (hw_q & 8'hD9) == ($past(hw_q) & 8'hD9))
        else $error("configuration restart pattern wrong");

    a_ot_sec_off: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        ovt_ev |=> ms_q[4:3] == 2'b00 ##1 !O_SECOND_REG_EN)
        else $error("second regulator not off after overtemperature");

    a_rsvd_zero: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        wr_hw |=> !hw_q[msc_pkg::HW_RSVD_BIT] && !snap_hw_q[msc_pkg::HW_RSVD_BIT])
        else $error("reserved bit set");

    a_soft_ro_low: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        soft_ev && !hw_q[6] |=> !O_RESET_OUT_N [*8])
        else $error("reset output not pulled low on soft reset");

    a_soft_ro_masked: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        soft_ev && hw_q[6] && O_RESET_OUT_N |=> O_RESET_OUT_N)
        else $error("reset output pulled despite mask");

    a_soft_keep: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        soft_ev && !restart_ev |=> hw_q == ($past(hw_q) & 8'h88) && ms_q == 8'h00)
        else $error("soft reset values wrong");

    a_fail_force: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        hw_q[5] |=> O_FAIL_OUT)
        else $error("failure output not forced");

    a_ov_escalate: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        ov_s |=> O_MAIN_OV_FLAG && (O_OV_ESCALATE == $past(ms_q[2])))
        else $error("overvoltage reaction wrong");

    a_read_static: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        wr_go && !word_q[7] && !restart_ev && !ovt_ev |=> $stable(hw_q) && $stable(ms_q))
        else $error("read changed a register");

    a_aux_uv_off: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        uv_s && !hw_q[4] |=> !O_AUX_REG_EN)
        else $error("aux regulator on at undervoltage");

    a_miso_lead_zero: assert property (@(negedge I_SPI_SCK) disable iff (spi_rst)
        cnt_q < 5'h08 |=> !O_SPI_MISO)
        else $error("first byte not zero");
endmodule

// *** inc/msc_pkg.sv ***
// shared constants for the mode and supply control register bank
package msc_pkg;
    // serial frame layout, least significant bit shifted first
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 7;
    localparam int RW_BIT = 7;
    localparam int DATA_LSB = 8;

    // register addresses
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HW_CONFIG = 7'h02;

    // power-on values; soft reset also loads MODE_SUPPLY_RST
    localparam logic [7:0] MODE_SUPPLY_RST = 8'h00;
    localparam logic [7:0] HW_CONFIG_RST = 8'h00;

    // mode_supply_control fields
    localparam int MS_MODE_LSB = 6;
    localparam int MS_AUX_EN_BIT = 5;
    localparam int MS_SEC_LSB = 3;
    localparam int MS_OV_RST_BIT = 2;
    localparam int MS_RT_LSB = 0;

    // hardware_configuration fields
    localparam int HW_AUX_VSEL_BIT = 7;
    localparam int HW_SOFT_RO_MASK_BIT = 6;
    localparam int HW_FO_FORCE_BIT = 5;
    localparam int HW_AUX_UV_KEEP_BIT = 4;
    localparam int HW_AUX_LS_BIT = 3;
    localparam int HW_RSVD_BIT = 2;
    localparam int HW_LS_STOP_BIT = 1;
    localparam int HW_WD_CFG_BIT = 0;

    // bits kept on restart / soft reset, writable bits
    localparam logic [7:0] MS_RESTART_KEEP = 8'h23;
    localparam logic [7:0] HW_RESTART_KEEP = 8'hD9;
    localparam logic [7:0] HW_SOFT_KEEP = 8'h88;
    localparam logic [7:0] HW_WRITE_MASK = 8'hFB;

    // reset output low time during soft reset
    localparam int REF_CLK_PERIOD_NS = 40;
    localparam int RO_LOW_NS = 2000;
    localparam int RO_LOW_CYC = (RO_LOW_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

    // watchdog trigger failures before escalation
    localparam int WD_FAILS_DEFAULT = 2;
    localparam int WD_FAILS_ALT = 1;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_STOP = 2'b10,
        MODE_SOFT_RESET = 2'b11
    } msc_mode_t;

    typedef enum logic [1:0] {
        SEC_OFF = 2'b00,
        SEC_NORMAL = 2'b01,
        SEC_NORMAL_STOP = 2'b10,
        SEC_ALWAYS = 2'b11
    } msc_sec_t;
endpackage

// *** hdl/msc_sync.sv ***
// two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module msc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_chk
        $error("msc_sync needs WIDTH of at least 1");
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// *** hdl/msc_wd_escalate.sv ***
// counts watchdog trigger failures and raises escalation
`timescale 1ns/1ps
module msc_wd_escalate (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_fail,
    input wire logic i_single,
    input wire logic i_clear,
    output logic o_escalate
);
    logic [1:0] count_q;
    logic [1:0] limit;

    assign limit = i_single ? 2'(msc_pkg::WD_FAILS_ALT) : 2'(msc_pkg::WD_FAILS_DEFAULT);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_q <= 2'h0;
        end else if (i_clear) begin
            count_q <= 2'h0;
        end else if (i_fail && count_q != 2'h3) begin
            count_q <= count_q + 2'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_escalate <= 1'b0;
        end else if (i_clear) begin
            o_escalate <= 1'b0;
        end else if (count_q >= limit) begin
            o_escalate <= 1'b1;
        end
    end
endmodule

// *** verification/msc_host_model.sv ***
// host-side serial master model driving 16-bit frames
`timescale 1ns/1ps
module msc_host_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [15:0] i_word,
    input wire logic i_miso,
    output logic o_sck,
    output logic o_csn,
    output logic o_mosi,
    output logic o_busy,
    output logic [15:0] o_rx
);
    initial begin
        o_sck = 1'b0;
        o_csn = 1'b1;
        o_mosi = 1'b0;
        o_busy = 1'b0;
        o_rx = 16'h0000;
    end

    // serial clock only runs inside a frame
    always @(posedge i_clk) begin
        if (i_go) begin
            // keep chip select off the reference clock edge
            #2;
            o_busy = 1'b1;
            o_csn = 1'b0;
            #15;
            for (int k = 0; k < 16; k++) begin
                o_mosi = i_word[k];
                #7.5 o_sck = 1'b1;
                o_rx[k] = i_miso;
                #7.5 o_sck = 1'b0;
            end
            #15 o_csn = 1'b1;
            // released line shows the inverse of its last value
            o_mosi = ~o_mosi;
            #200 o_busy = 1'b0;
        end
    end
endmodule

// *** verification/tb_spi_mode_supply_control_regs.sv ***
// self-checking bench for the mode and supply register bank
`timescale 1ns/1ps
module tb_spi_mode_supply_control_regs;
    logic clk;
    logic rst = 1'b1;
    logic restart = 1'b0;
    logic overtemp = 1'b0;
    logic ov = 1'b0;
    logic uv = 1'b0;
    logic failure = 1'b0;
    logic wdf = 1'b0;
    logic fsafe = 1'b0;
    logic sec_en, soft_req, miso_oe;
    logic go = 1'b0;
    logic [15:0] word = 16'h0000;
    logic sck, csn, mosi, miso, busy;
    logic [15:0] rx;
    logic [1:0] mode;
    logic [1:0] rt;
    logic rstn, aux_en, vsel, ls, ls_stop, ovf, ovesc, wdesc, fout;
    logic [7:0] ms = 8'h00;
    logic [7:0] hw = 8'h00;
    logic [7:0] d;
    logic ovs = 1'b0;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int soft_cnt = 0;
    int soft_exp = 0;
    int seed;
    int r;

    msc_regs dut (.I_REF_CLK(clk), .I_RST(rst), .I_SPI_SCK(sck), .I_SPI_CSN(csn),
        .I_SPI_MOSI(mosi), .O_SPI_MISO(miso), .O_SPI_MISO_OE(miso_oe), .I_RESTART(restart),
        .I_OVERTEMP(overtemp), .I_MAIN_OV(ov), .I_SUPPLY_UV(uv), .I_FAILURE(failure),
        .I_FAIL_SAFE(fsafe), .I_WD_TRIG_FAIL(wdf), .O_MODE(mode), .O_SOFT_RESET_REQ(soft_req),
        .O_RESET_OUT_N(rstn), .O_SECOND_REG_EN(sec_en), .O_AUX_REG_EN(aux_en), .O_AUX_VSEL(vsel),
        .O_AUX_LOAD_SHARE(ls), .O_AUX_LS_STOP(ls_stop), .O_RESET_THRESHOLD(rt),
        .O_MAIN_OV_FLAG(ovf), .O_OV_ESCALATE(ovesc), .O_WD_ESCALATE(wdesc), .O_FAIL_OUT(fout));

    msc_host_model host (.i_clk(clk), .i_go(go), .i_word(word), .i_miso(miso), .o_sck(sck),
        .o_csn(csn), .o_mosi(mosi), .o_busy(busy), .o_rx(rx));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        // one-cycle pulse counted at the edge after it is launched
        if (soft_req === 1'b1) soft_cnt++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task xfer(input logic [6:0] a, input logic w, input logic [7:0] dd, output logic [7:0] q);
        int n;
        n = 0;
        go <= 1'b1;
        word <= {dd, w, a};
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (n == 1) chk("oe", {7'h00, miso_oe}, 8'h01);
        end while (busy && n < 200);
        q = rx[15:8];
        repeat (3) @(posedge clk);
    endtask

    task outs;
        logic sec;
        ovs = ovs | ov;
        case (ms[4:3])
            2'b01: sec = (ms[7:6] == 2'b00);
            2'b10: sec = (ms[7:6] == 2'b00) || (ms[7:6] == 2'b10);
            2'b11: sec = ~fsafe;
            default: sec = 1'b0;
        endcase
        chk("second", {6'h00, miso_oe, sec_en}, {6'h00, 1'b0, sec});
        chk("softreq", 8'(soft_cnt), 8'(soft_exp));
        chk("outs", {mode, rt, vsel, ls, ls_stop, fout},
            {ms[7:6], ms[1:0], hw[7], hw[3], hw[3] & hw[1], hw[5] | failure});
        chk("supply", {5'h00, ovf, ovesc, aux_en},
            {5'h00, ovs, ov & ms[2], ms[5] & ~(uv & ~hw[4])});
    endtask

    task access(input logic [6:0] a, input logic w, input logic [7:0] din);
        logic [7:0] old;
        logic [7:0] q;
        logic [7:0] dd;
        dd = (a == msc_pkg::ADDR_HW_CONFIG) ? (din & 8'hfb) : din;
        old = (a == msc_pkg::ADDR_MODE_SUPPLY) ? ms : (a == msc_pkg::ADDR_HW_CONFIG) ? hw : 8'h00;
        xfer(a, w, dd, q);
        chk("read", q, old);
        if (w && a == msc_pkg::ADDR_MODE_SUPPLY) begin
            if (dd[7:6] == 2'b11) begin
                soft_exp++;
                ms = 8'h00;
                hw = hw & 8'h88;
            end else if (ms[7:6] == 2'b10 && dd[7:6] == 2'b01) ms = {2'b10, dd[5:0]};
            else ms = dd;
        end
        if (w && a == msc_pkg::ADDR_HW_CONFIG) hw = dd;
        outs();
    endtask

    task pulse(input int which);
        if (which == 0) restart <= 1'b1;
        else if (which == 1) overtemp <= 1'b1;
        else wdf <= 1'b1;
        repeat (4) @(posedge clk);
        restart <= 1'b0;
        overtemp <= 1'b0;
        wdf <= 1'b0;
        repeat (6) @(posedge clk);
        if (which == 0) begin
            ms = ms & 8'h23;
            hw = hw & 8'hd9;
        end
        if (which == 1) ms[4:3] = 2'b00;
    endtask

    initial begin
        seed = 32'h989b;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("rstn", {7'h00, rstn}, 8'h01);
        access(7'h01, 1'b0, 8'h00);
        access(7'h02, 1'b0, 8'h00);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            d = 8'($random(seed));
            if (d[7:6] == 2'b11) d[7:6] = 2'b10;
            uv <= r[4];
            failure <= r[5];
            fsafe <= r[7];
            if (i >= 20) ov <= r[6];
            access((i % 5 == 0) ? 7'h03 : (i % 7 == 0) ? 7'h7f : {5'h00, 1'b1 + r[0], r[1]},
                r[2], d);
        end
        access(7'h01, 1'b1, 8'h80);
        access(7'h01, 1'b1, 8'h40);
        access(7'h01, 1'b0, 8'h00);
        access(7'h01, 1'b1, 8'hbf);
        access(7'h02, 1'b1, 8'hff);
        pulse(0);
        access(7'h01, 1'b0, 8'h00);
        access(7'h02, 1'b0, 8'h00);
        access(7'h01, 1'b1, 8'h18);
        pulse(1);
        access(7'h01, 1'b0, 8'h00);
        access(7'h02, 1'b1, 8'h89);
        access(7'h01, 1'b1, 8'hc0);
        chk("rstn", {7'h00, rstn}, 8'h00);
        repeat (60) @(posedge clk);
        chk("rstn", {7'h00, rstn}, 8'h01);
        access(7'h02, 1'b0, 8'h00);
        access(7'h02, 1'b1, 8'h40);
        access(7'h01, 1'b1, 8'hc0);
        chk("rstn", {7'h00, rstn}, 8'h01);
        access(7'h02, 1'b1, 8'h00);
        pulse(2);
        chk("wdesc", {7'h00, wdesc}, 8'h00);
        pulse(2);
        chk("wdesc", {7'h00, wdesc}, 8'h01);
        pulse(0);
        chk("wdesc", {7'h00, wdesc}, 8'h00);
        access(7'h02, 1'b1, 8'h01);
        pulse(2);
        chk("wdesc", {7'h00, wdesc}, 8'h01);
        give_verdict();
    end
endmodule
